// *** crs_params.svh ***
// Constants of the CPU register set: bus offsets, field positions, reset values and counts.
// Assumes inclusion by bare name from the register set and its package users.
`ifndef CRS_PARAMS_SVH
`define CRS_PARAMS_SVH

// Byte offsets of the software-visible words on the register bus.
`define CRS_OFF_MODE1    8'h00
`define CRS_OFF_FLAGS    8'h04
`define CRS_OFF_ACCE     8'h08
`define CRS_OFF_INDEX    8'h0C
`define CRS_OFF_STACK    8'h10
`define CRS_OFF_PC       8'h14
`define CRS_OFF_DPLO     8'h18
`define CRS_OFF_DPHI     8'h1C

// Field positions.
`define CRS_BIT_DPSW     1
`define CRS_BIT_ROMCYC   7
`define CRS_BIT_M        0
`define CRS_BIT_X        1

// Reset values.
`define CRS_MODE1_RST    8'h00
`define CRS_SP_RST       16'h0FFF
`define CRS_PC_RST       16'hFFFE
`define CRS_BANK_RST     8'h00
`define CRS_DIRECT_PAGE_BASE_ZERO_RST     16'h0000
`define CRS_STACK_BANK   8'h00

// Positions in the saved-context list, deepest stack byte first.
`define CRS_POS_PG       3'h0
`define CRS_POS_PCH      3'h1
`define CRS_POS_PCL      3'h2
`define CRS_POS_PSH      3'h3
`define CRS_POS_PSL      3'h4

// Direct page area sizes in bytes.
`define CRS_DP_AREA_ONE  256
`define CRS_DP_AREA_FOUR 64

`endif

// *** crs_pkg.sv ***
// Types shared by the CPU register set: core commands, register selects and sequencer states.
// Assumes nothing of its surroundings.
package crs_pkg;

  // Commands issued by the instruction sequencer.
  typedef enum logic [3:0] {
    CRS_OP_NOP        = 4'h0,
    CRS_OP_WRITE      = 4'h1,
    CRS_OP_INT_ENTRY  = 4'h2,
    CRS_OP_INT_RETURN = 4'h3,
    CRS_OP_CALL_SHORT = 4'h4,
    CRS_OP_CALL_LONG  = 4'h5,
    CRS_OP_RET_SHORT  = 4'h6,
    CRS_OP_RET_LONG   = 4'h7,
    CRS_OP_PC_ADD     = 4'h8,
    CRS_OP_LOAD_DT    = 4'h9
  } crs_op_e;

  // Targets of a register write.
  typedef enum logic [2:0] {
    CRS_REG_A  = 3'h0,
    CRS_REG_B  = 3'h1,
    CRS_REG_X  = 3'h2,
    CRS_REG_Y  = 3'h3,
    CRS_REG_SP = 3'h4,
    CRS_REG_E  = 3'h5
  } crs_reg_e;

  // Stack sequencer states.
  typedef enum logic [2:0] {
    CRS_ST_VECTOR   = 3'h0,
    CRS_ST_IDLE     = 3'h1,
    CRS_ST_PUSH     = 3'h2,
    CRS_ST_POP_ADDR = 3'h3,
    CRS_ST_POP_DATA = 3'h4
  } crs_state_e;

endpackage

// *** crs_stack_ram.sv ***
// Byte-wide single-port stack memory standing in bank zero below the stack pointer.
// Assumes one clock; read data appear one edge after the address.
`timescale 1ns/1ps
module crs_stack_ram #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  output logic      [7:0]        rdata
);

  logic [7:0] mem [0:(1<<ADDR_W)-1];

  // Write and registered read share one address; a pop never writes.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

// *** crs_regset.sv ***
// Programmer-visible register set of a 16-bit core: accumulators, index registers,
// stack pointer with context save, program counter, banks and direct page bases.
// Assumes the instruction sequencer drives the command port on CLK_SYS and that
// software reaches the mode and flag words over APB.
//
// Overview of operation
// - Accumulator B matches A, including 8-bit use under data length flag.
// - The 32-bit accumulator is B high, A low, regardless of data length.
// - Index X is 16 bits; in 8-bit mode only its low byte is used.
// - Indexed address is operand plus index register contents.
// - Index Y behaves like X, width chosen by index length flag.
// - Stack pointer is 16 bits; stack accesses go to bank zero.
// - Interrupt pushes bank, counter and status word; pointer drops by five.
// - Interrupt return pops status, counter, bank; pointer restored.
// - Calls push return address without status; bank saved by mode.
// - No other registers are saved automatically on interrupt or call.
// - Stack pointer resets to 0FFF hex.
// - Program counter gives low 16 bits of next fetch address.
// - Counter resets to FFFE, then loads the reset vector.
// - Program bank follows counter carry and borrow; resets to 00.
// - Data bank supplies bank byte of data addresses.
// - Data bank written only by its load instruction; resets to 00.
// - Direct page bases give area start in bank zero or zero and one.
// - Switch 0 uses base zero for 256 bytes; 1 uses four 64-byte areas.
// - Base zero clears at reset; the other three bases stay undefined.
// - Mode one bit 1 is direct page switch, reset 0; bits 6..2 kept zero; the code stores them as written.
// - Mode one bit 7 selects two- or three-phase ROM cycle; resets 0.
// - An 8-bit accumulator operation leaves the high byte unchanged.
// - Data length flag: 0 sixteen-bit, 1 eight-bit; clears at reset.
// - Index length flag: 0 sixteen-bit, 1 eight-bit; clears at reset.
`timescale 1ns/1ps
`include "crs_params.svh"
module crs_regset #(
  parameter int STACK_AW = 8
) (
  input  wire logic              CLK_SYS,
  input  wire logic              RST,
  input  wire logic [7:0]        PADDR,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic              OP_VALID,
  input  crs_pkg::crs_op_e       OP_CODE,
  input  crs_pkg::crs_reg_e      OP_SEL,
  input  wire logic [31:0]       OP_DATA,
  output logic                   OP_READY,
  input  wire logic [15:0]       STATUS_IN,
  input  wire logic [15:0]       RESET_VECTOR,
  input  wire logic [15:0]       OPERAND,
  input  wire logic              INDEX_SEL,
  input  wire logic [7:0]        DP_OFFSET,
  output logic      [15:0]       ACC_A,
  output logic      [15:0]       ACC_B,
  output logic      [31:0]       ACC_E,
  output logic      [15:0]       INDEX_X,
  output logic      [15:0]       INDEX_Y,
  output logic      [15:0]       STACK_PTR,
  output logic      [15:0]       PROG_CNT,
  output logic      [7:0]        PROG_BANK,
  output logic      [7:0]        DATA_BANK,
  output logic      [23:0]       INDEXED_ADDR,
  output logic      [23:0]       DIRECT_ADDR,
  output logic      [15:0]       STATUS_OUT,
  output logic                   STATUS_LOAD,
  output logic                   DATA_LEN_8,
  output logic                   INDEX_LEN_8,
  output logic                   DP_SWITCH,
  output logic                   ROM_CYCLE_TWO
);

  crs_pkg::crs_state_e state;
  logic [15:0]         acc_a;
  logic [15:0]         acc_b;
  logic [15:0]         idx_x;
  logic [15:0]         idx_y;
  logic [15:0]         sp;
  logic [15:0]         pc;
  logic [7:0]          pg;
  logic [7:0]          dt;
  logic [7:0]          mode1;
  logic                flag_m;
  logic                flag_x;
  logic [15:0]         dpr [0:3];
  logic [2:0]          seq_pos;
  logic [2:0]          seq_last;
  logic                seq_long;
  logic [15:0]         ps_hold;
  logic [23:0]         target;
  logic [7:0]          push_byte;
  logic [7:0]          ram_rdata;
  logic                ram_we;
  logic [STACK_AW-1:0] ram_addr;
  logic                take;
  logic                apb_wr;
  logic                apb_setup;
  logic [15:0]         eff_index;
  logic [16:0]         dp_sum;
  logic [23:0]         pc_sum;

  assign take      = OP_VALID && (state == crs_pkg::CRS_ST_IDLE);
  assign OP_READY  = (state == crs_pkg::CRS_ST_IDLE);
  assign apb_wr    = PSEL && PENABLE && PWRITE;
  assign apb_setup = PSEL && !PENABLE;
  assign PREADY    = 1'b1;

  // Accumulators; 8-bit writes touch only the low byte.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      acc_a <= 16'h0000;
      acc_b <= 16'h0000;
    end else if (take && OP_CODE == crs_pkg::CRS_OP_WRITE) begin
      case (OP_SEL)
        crs_pkg::CRS_REG_A: begin
          acc_a[7:0] <= OP_DATA[7:0];
          if (!flag_m) acc_a[15:8] <= OP_DATA[15:8];
        end
        crs_pkg::CRS_REG_B: begin
          acc_b[7:0] <= OP_DATA[7:0];
          if (!flag_m) acc_b[15:8] <= OP_DATA[15:8];
        end
        crs_pkg::CRS_REG_E: begin
          // The paired accumulator ignores the data length flag.
          acc_a <= OP_DATA[15:0];
          acc_b <= OP_DATA[31:16];
        end
        default: begin
        end
      endcase
    end
  end

  // Index registers; in 8-bit mode the high byte is kept.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      idx_x <= 16'h0000;
      idx_y <= 16'h0000;
    end else if (take && OP_CODE == crs_pkg::CRS_OP_WRITE) begin
      if (OP_SEL == crs_pkg::CRS_REG_X) begin
        idx_x[7:0] <= OP_DATA[7:0];
        if (!flag_x) idx_x[15:8] <= OP_DATA[15:8];
      end
      if (OP_SEL == crs_pkg::CRS_REG_Y) begin
        idx_y[7:0] <= OP_DATA[7:0];
        if (!flag_x) idx_y[15:8] <= OP_DATA[15:8];
      end
    end
  end

  // Sequencer: only bank, counter and status move through the stack.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state    <= crs_pkg::CRS_ST_VECTOR;
      seq_pos  <= 3'h0;
      seq_last <= 3'h0;
      seq_long <= 1'b0;
      ps_hold  <= 16'h0000;
      target   <= 24'h000000;
    end else begin
      case (state)
        crs_pkg::CRS_ST_VECTOR: begin
          state <= crs_pkg::CRS_ST_IDLE;
        end
        crs_pkg::CRS_ST_IDLE: begin
          if (take) begin
            ps_hold  <= STATUS_IN;
            target   <= OP_DATA[23:0];
            seq_long <= (OP_CODE != crs_pkg::CRS_OP_CALL_SHORT);
            case (OP_CODE)
              crs_pkg::CRS_OP_INT_ENTRY: begin
                seq_pos  <= `CRS_POS_PG;
                seq_last <= `CRS_POS_PSL;
                state    <= crs_pkg::CRS_ST_PUSH;
              end
              crs_pkg::CRS_OP_CALL_LONG: begin
                seq_pos  <= `CRS_POS_PG;
                seq_last <= `CRS_POS_PCL;
                state    <= crs_pkg::CRS_ST_PUSH;
              end
              crs_pkg::CRS_OP_CALL_SHORT: begin
                seq_pos  <= `CRS_POS_PCH;
                seq_last <= `CRS_POS_PCL;
                state    <= crs_pkg::CRS_ST_PUSH;
              end
              crs_pkg::CRS_OP_INT_RETURN: begin
                seq_pos  <= `CRS_POS_PSL;
                seq_last <= `CRS_POS_PG;
                state    <= crs_pkg::CRS_ST_POP_ADDR;
              end
              crs_pkg::CRS_OP_RET_LONG: begin
                seq_pos  <= `CRS_POS_PCL;
                seq_last <= `CRS_POS_PG;
                state    <= crs_pkg::CRS_ST_POP_ADDR;
              end
              crs_pkg::CRS_OP_RET_SHORT: begin
                seq_pos  <= `CRS_POS_PCL;
                seq_last <= `CRS_POS_PCH;
                state    <= crs_pkg::CRS_ST_POP_ADDR;
              end
              default: begin
              end
            endcase
          end
        end
        crs_pkg::CRS_ST_PUSH: begin
          if (seq_pos == seq_last) begin
            state <= crs_pkg::CRS_ST_IDLE;
          end else begin
            seq_pos <= seq_pos + 3'h1;
          end
        end
        crs_pkg::CRS_ST_POP_ADDR: begin
          state <= crs_pkg::CRS_ST_POP_DATA;
        end
        crs_pkg::CRS_ST_POP_DATA: begin
          if (seq_pos == seq_last) begin
            state <= crs_pkg::CRS_ST_IDLE;
          end else begin
            seq_pos <= seq_pos - 3'h1;
            state   <= crs_pkg::CRS_ST_POP_ADDR;
          end
        end
        default: begin
          state <= crs_pkg::CRS_ST_IDLE;
        end
      endcase
    end
  end

  // Byte pushed at the current stack pointer.
  always_comb begin
    case (seq_pos)
      `CRS_POS_PG:  push_byte = pg;
      `CRS_POS_PCH: push_byte = pc[15:8];
      `CRS_POS_PCL: push_byte = pc[7:0];
      `CRS_POS_PSH: push_byte = ps_hold[15:8];
      default:      push_byte = ps_hold[7:0];
    endcase
  end

  // Push writes at the pointer; pop reads one above it. The stack lives in bank zero,
  // so only the pointer's low bits address the memory.
  assign ram_we   = (state == crs_pkg::CRS_ST_PUSH);
  assign ram_addr = (state == crs_pkg::CRS_ST_POP_ADDR) ? STACK_AW'(sp + 16'h0001)
                                                        : sp[STACK_AW-1:0];

  crs_stack_ram #(
    .ADDR_W (STACK_AW)
  ) u_stack (
    .clk   (CLK_SYS),
    .we    (ram_we),
    .addr  (ram_addr),
    .wdata (push_byte),
    .rdata (ram_rdata)
  );

  // Stack pointer: down one per push, up one per pop.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sp <= `CRS_SP_RST;
    end else if (state == crs_pkg::CRS_ST_PUSH) begin
      sp <= sp - 16'h0001;
    end else if (state == crs_pkg::CRS_ST_POP_ADDR) begin
      sp <= sp + 16'h0001;
    end else if (take && OP_CODE == crs_pkg::CRS_OP_WRITE && OP_SEL == crs_pkg::CRS_REG_SP) begin
      sp <= OP_DATA[15:0];
    end
  end

  // Relative add on the 24-bit fetch address; carry or borrow moves the bank.
  assign pc_sum = {pg, pc} + {{8{OP_DATA[15]}}, OP_DATA[15:0]};

  // Program counter and bank: reset vector, relative add, jumps and pops.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pc <= `CRS_PC_RST;
      pg <= `CRS_BANK_RST;
    end else begin
      case (state)
        crs_pkg::CRS_ST_VECTOR: begin
          pc <= RESET_VECTOR;
        end
        crs_pkg::CRS_ST_IDLE: begin
          if (take && OP_CODE == crs_pkg::CRS_OP_PC_ADD) begin
            pc <= pc_sum[15:0];
            pg <= pc_sum[23:16];
          end
        end
        crs_pkg::CRS_ST_PUSH: begin
          // Jump only after the return address has been saved.
          if (seq_pos == seq_last) begin
            pc <= target[15:0];
            if (seq_long) pg <= target[23:16];
          end
        end
        crs_pkg::CRS_ST_POP_DATA: begin
          if (seq_pos == `CRS_POS_PCH) pc[15:8] <= ram_rdata;
          if (seq_pos == `CRS_POS_PCL) pc[7:0]  <= ram_rdata;
          if (seq_pos == `CRS_POS_PG)  pg       <= ram_rdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Restored status word, announced by a one-cycle pulse as its high byte arrives.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      STATUS_OUT  <= 16'h0000;
      STATUS_LOAD <= 1'b0;
    end else begin
      STATUS_LOAD <= 1'b0;
      if (state == crs_pkg::CRS_ST_POP_DATA && seq_pos == `CRS_POS_PSL) begin
        STATUS_OUT[7:0] <= ram_rdata;
      end
      if (state == crs_pkg::CRS_ST_POP_DATA && seq_pos == `CRS_POS_PSH) begin
        STATUS_OUT[15:8] <= ram_rdata;
        STATUS_LOAD      <= 1'b1;
      end
    end
  end

  // Data bank: only the load instruction writes it; software can only read.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      dt <= `CRS_BANK_RST;
    end else if (take && OP_CODE == crs_pkg::CRS_OP_LOAD_DT) begin
      dt <= OP_DATA[7:0];
    end
  end

  // Mode word and length flags. Bits 6..2 are stored as written; keeping them zero
  // is left to software.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      mode1  <= `CRS_MODE1_RST;
      flag_m <= 1'b0;
      flag_x <= 1'b0;
    end else if (apb_wr) begin
      if (PADDR == `CRS_OFF_MODE1) mode1 <= PWDATA[7:0];
      if (PADDR == `CRS_OFF_FLAGS) begin
        flag_m <= PWDATA[`CRS_BIT_M];
        flag_x <= PWDATA[`CRS_BIT_X];
      end
    end
  end

  // Base zero clears at reset.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      dpr[0] <= `CRS_DIRECT_PAGE_BASE_ZERO_RST;
    end else if (apb_wr && PADDR == `CRS_OFF_DPLO) begin
      dpr[0] <= PWDATA[15:0];
    end
  end

  // Bases one to three have no reset, which saves flops; their value is unknown.
  always_ff @(posedge CLK_SYS) begin
    if (apb_wr && PADDR == `CRS_OFF_DPLO) dpr[1] <= PWDATA[31:16];
    if (apb_wr && PADDR == `CRS_OFF_DPHI) begin
      dpr[2] <= PWDATA[15:0];
      dpr[3] <= PWDATA[31:16];
    end
  end

  // Effective index: 8-bit mode zero-extends the low byte.
  assign eff_index = INDEX_SEL ? (flag_x ? {8'h00, idx_y[7:0]} : idx_y)
                               : (flag_x ? {8'h00, idx_x[7:0]} : idx_x);

  // Direct page sum may run into bank one.
  assign dp_sum = mode1[`CRS_BIT_DPSW] ?
                  {1'b0, dpr[DP_OFFSET[7:6]]} + {11'h000, DP_OFFSET[5:0]} :
                  {1'b0, dpr[0]} + {9'h000, DP_OFFSET};

  // Address outputs registered for timing.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      INDEXED_ADDR <= 24'h000000;
      DIRECT_ADDR  <= 24'h000000;
    end else begin
      INDEXED_ADDR <= {dt, OPERAND} + {8'h00, eff_index};
      DIRECT_ADDR  <= {7'h00, dp_sum};
    end
  end

  // APB read data and error are captured in the setup cycle; zero-wait access.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else if (apb_setup) begin
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
      case (PADDR)
        `CRS_OFF_MODE1: PRDATA <= {24'h000000, mode1};
        `CRS_OFF_FLAGS: PRDATA <= {30'h0, flag_x, flag_m};
        `CRS_OFF_ACCE:  PRDATA <= {acc_b, acc_a};
        `CRS_OFF_INDEX: PRDATA <= {idx_y, idx_x};
        `CRS_OFF_STACK: PRDATA <= {dt, pg, sp};
        `CRS_OFF_PC:    PRDATA <= {16'h0000, pc};
        `CRS_OFF_DPLO:  PRDATA <= {dpr[1], dpr[0]};
        `CRS_OFF_DPHI:  PRDATA <= {dpr[3], dpr[2]};
        default:        PSLVERR <= 1'b1;
      endcase
    end
  end

  assign ACC_A         = acc_a;
  assign ACC_B         = acc_b;
  assign ACC_E         = {acc_b, acc_a};
  assign INDEX_X       = idx_x;
  assign INDEX_Y       = idx_y;
  assign STACK_PTR     = sp;
  assign PROG_CNT      = pc;
  assign PROG_BANK     = pg;
  assign DATA_BANK     = dt;
  assign DATA_LEN_8    = flag_m;
  assign INDEX_LEN_8   = flag_x;
  assign DP_SWITCH     = mode1[`CRS_BIT_DPSW];
  assign ROM_CYCLE_TWO = mode1[`CRS_BIT_ROMCYC];

endmodule

// *** crs_regset_sva.sv ***
// Checker for the CPU register set: bus answers, stack sequencing and bank updates.
// Assumes it is bound to crs_regset, with the shared package compiled first.
`timescale 1ns/1ps
module crs_regset_chk (
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic [7:0]  PADDR,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PWDATA,
  input wire logic        PSLVERR,
  input wire logic        OP_VALID,
  input crs_pkg::crs_op_e OP_CODE,
  input crs_pkg::crs_reg_e OP_SEL,
  input wire logic        STATUS_LOAD,
  input wire logic [31:0] OP_DATA,
  input wire logic        OP_READY,
  input wire logic [15:0] ACC_A,
  input wire logic [15:0] ACC_B,
  input wire logic [31:0] ACC_E,
  input wire logic [15:0] STACK_PTR,
  input wire logic [15:0] PROG_CNT,
  input wire logic [7:0]  PROG_BANK,
  input wire logic [7:0]  DATA_BANK,
  input wire logic        DATA_LEN_8,
  input wire logic        INDEX_LEN_8,
  input wire logic        DP_SWITCH,
  input wire logic        ROM_CYCLE_TWO
);
  // Command takes are decoded once so that the properties stay short.
  logic take;
  logic ld_dt;
  assign take  = OP_VALID && OP_READY;
  assign ld_dt = take && OP_CODE == crs_pkg::CRS_OP_LOAD_DT;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // A wide write ignores the data length flag.
  a_acc_pair: assert property (take && OP_CODE == crs_pkg::CRS_OP_WRITE
    && OP_SEL == crs_pkg::CRS_REG_E |=> ACC_E == $past(OP_DATA))
    else $error("wide accumulator write wrong");
  a_int_len: assert property (take && OP_CODE == crs_pkg::CRS_OP_INT_ENTRY
    |=> !OP_READY [*5] ##1 OP_READY) else $error("interrupt entry length wrong");
  a_int_sp: assert property (take && OP_CODE == crs_pkg::CRS_OP_INT_ENTRY
    |-> ##6 STACK_PTR == $past(STACK_PTR, 6) - 16'h0005)
    else $error("stack pointer not five lower after interrupt entry");
  a_ret_len: assert property (take && OP_CODE == crs_pkg::CRS_OP_INT_RETURN
    |=> !OP_READY [*8] ##[2:4] OP_READY) else $error("interrupt return length wrong");
  a_stat_pulse: assert property (take && OP_CODE == crs_pkg::CRS_OP_INT_RETURN
    |-> ##5 STATUS_LOAD ##1 !STATUS_LOAD) else $error("status load pulse wrong");
  a_bank_carry: assert property (take && OP_CODE == crs_pkg::CRS_OP_PC_ADD
    |=> {PROG_BANK, PROG_CNT} == $past({PROG_BANK, PROG_CNT})
      + {{8{$past(OP_DATA[15])}}, $past(OP_DATA[15:0])})
    else $error("program bank did not follow the counter");
  a_dt_only: assert property (!$stable(DATA_BANK) |-> $past(ld_dt) || $past(RST))
    else $error("data bank changed without its load command");
  a_bus_err: assert property (PSEL && !PENABLE && PADDR[1:0] == 2'h0
    |=> PSLVERR == ($past(PADDR) > 8'h1C)) else $error("error response wrong");
  a_mode_wr: assert property (PSEL && PENABLE && PWRITE && PADDR == 8'h00
    |=> DP_SWITCH == $past(PWDATA[1]) && ROM_CYCLE_TWO == $past(PWDATA[7]))
    else $error("mode bits did not take the written value");
  a_rst_val: assert property ($fell(RST) |-> STACK_PTR == 16'h0FFF
    && PROG_CNT == 16'hFFFE && PROG_BANK == 8'h00 && DATA_BANK == 8'h00
    && !DP_SWITCH && !ROM_CYCLE_TWO && !DATA_LEN_8 && !INDEX_LEN_8)
    else $error("register reset values wrong");

  // Main scenarios worth seeing at least once.
  c_int: cover property (take && OP_CODE == crs_pkg::CRS_OP_INT_ENTRY);
  c_err: cover property (PSLVERR);
  c_dp4: cover property (DP_SWITCH);
endmodule

bind crs_regset crs_regset_chk i_chk (.CLK_SYS, .RST, .PADDR, .PSEL, .PENABLE, .PWRITE,
  .PWDATA, .PSLVERR, .OP_VALID, .OP_CODE, .OP_DATA, .OP_READY, .ACC_A, .ACC_B, .ACC_E,
  .STACK_PTR, .PROG_CNT, .PROG_BANK, .DATA_BANK, .DATA_LEN_8, .INDEX_LEN_8, .DP_SWITCH,
  .ROM_CYCLE_TWO, .OP_SEL, .STATUS_LOAD);

// *** crs_regset_tb.sv ***
// Testbench for the CPU register set: APB and command-port sequences with expected values.
// Assumes the package, the register set and its checker are compiled before this file.
`timescale 1ns/1ps
module crs_regset_tb;
  logic              CLK_SYS, RST, PSEL, PENABLE, PWRITE, OP_VALID, INDEX_SEL, err;
  logic              PREADY, PSLVERR, OP_READY, STATUS_LOAD;
  logic              DATA_LEN_8, INDEX_LEN_8, DP_SWITCH, ROM_CYCLE_TWO;
  logic [7:0]        PADDR, DP_OFFSET, PROG_BANK, DATA_BANK;
  logic [15:0]       STATUS_IN, OPERAND, ACC_A, ACC_B, INDEX_X, INDEX_Y;
  logic [15:0]       STACK_PTR, PROG_CNT, STATUS_OUT;
  logic [23:0]       INDEXED_ADDR, DIRECT_ADDR;
  logic [31:0]       PWDATA, PRDATA, OP_DATA, ACC_E, rd;
  crs_pkg::crs_op_e  OP_CODE;
  crs_pkg::crs_reg_e OP_SEL;
  int                n_errors, cmp_count;

  crs_regset i_dut (.CLK_SYS, .RST, .PADDR, .PSEL, .PENABLE, .PWRITE, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .OP_VALID, .OP_CODE, .OP_SEL, .OP_DATA, .OP_READY, .STATUS_IN,
    .RESET_VECTOR(16'h1234), .OPERAND, .INDEX_SEL, .DP_OFFSET, .ACC_A, .ACC_B, .ACC_E,
    .INDEX_X, .INDEX_Y, .STACK_PTR, .PROG_CNT, .PROG_BANK, .DATA_BANK, .INDEXED_ADDR,
    .DIRECT_ADDR, .STATUS_OUT, .STATUS_LOAD, .DATA_LEN_8, .INDEX_LEN_8, .DP_SWITCH,
    .ROM_CYCLE_TWO);

  // Free-running system clock of 100 MHz.
  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  // Comparison with case inequality, so an unknown is never taken for a match.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic ctx(input logic [15:0] pc, input logic [7:0] pg, input logic [15:0] sp);
    chk("pc", 32'(pc), 32'(PROG_CNT));
    chk("bank", 32'(pg), 32'(PROG_BANK));
    chk("sp", 32'(sp), 32'(STACK_PTR));
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do @(posedge CLK_SYS); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // One command; it is held until taken, then the port is idle again.
  task automatic op(input crs_pkg::crs_op_e c, input logic [31:0] d,
                    input crs_pkg::crs_reg_e s = crs_pkg::CRS_REG_A);
    @(posedge CLK_SYS);
    OP_VALID <= 1'b1;
    OP_CODE  <= c;
    OP_SEL   <= s;
    OP_DATA  <= d;
    do @(posedge CLK_SYS); while (OP_READY !== 1'b1);
    OP_VALID <= 1'b0;
    do @(posedge CLK_SYS); while (OP_READY !== 1'b1);
  endtask

  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A hang is cut short far beyond the 150 or so cycles the run needs.
  initial begin
    #100000;
    n_errors++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    {RST, PSEL, PENABLE, PWRITE, OP_VALID, INDEX_SEL} = 6'h20;
    {PADDR, DP_OFFSET, PWDATA, OP_DATA} = '0;
    {STATUS_IN, OPERAND} = {16'hBEEF, 16'h0000};
    OP_CODE = crs_pkg::CRS_OP_NOP;
    OP_SEL  = crs_pkg::CRS_REG_A;
    repeat (12) @(posedge CLK_SYS);
    RST <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    ctx(16'h1234, 8'h00, 16'h0FFF);
    chk("dt", 32'h0, 32'(DATA_BANK));
    apb(1'b0, 8'h00, 32'h0);
    chk("mode", 32'h0, rd);
    apb(1'b0, 8'h18, 32'h0);
    chk("dp0", 32'h0, 32'(rd[15:0]));
    apb(1'b0, 8'h04, 32'h0);
    chk("flags", 32'h0, rd);
    apb(1'b1, 8'h20, 32'h5);
    chk("unmapped", 32'h1, 32'(err));
    apb(1'b1, 8'h00, 32'h82);
    apb(1'b0, 8'h00, 32'h0);
    chk("mode", 32'h82, rd);
    chk("mode out", 32'h3, {30'h0, ROM_CYCLE_TWO, DP_SWITCH});
    // Wide and narrow register writes, before and after the length flags are set.
    op(crs_pkg::CRS_OP_WRITE, 32'hABCD, crs_pkg::CRS_REG_A);
    op(crs_pkg::CRS_OP_WRITE, 32'h1234, crs_pkg::CRS_REG_B);
    op(crs_pkg::CRS_OP_WRITE, 32'h1100, crs_pkg::CRS_REG_X);
    op(crs_pkg::CRS_OP_WRITE, 32'h2200, crs_pkg::CRS_REG_Y);
    chk("e", 32'h1234ABCD, ACC_E);
    apb(1'b1, 8'h04, 32'h3);
    op(crs_pkg::CRS_OP_WRITE, 32'h5555, crs_pkg::CRS_REG_A);
    op(crs_pkg::CRS_OP_WRITE, 32'h6666, crs_pkg::CRS_REG_B);
    op(crs_pkg::CRS_OP_WRITE, 32'h77EE, crs_pkg::CRS_REG_X);
    op(crs_pkg::CRS_OP_WRITE, 32'h7733, crs_pkg::CRS_REG_Y);
    chk("e narrow", 32'h1266AB55, ACC_E);
    chk("x", 32'h11EE, 32'(INDEX_X));
    chk("y", 32'h2233, 32'(INDEX_Y));
    // Indexed addresses with narrow and then wide index registers.
    op(crs_pkg::CRS_OP_LOAD_DT, 32'h12);
    OPERAND <= 16'h1000;
    repeat (2) @(posedge CLK_SYS);
    chk("idx x8", 32'h1210EE, 32'(INDEXED_ADDR));
    INDEX_SEL <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    chk("idx y8", 32'h121033, 32'(INDEXED_ADDR));
    apb(1'b1, 8'h04, 32'h1);
    INDEX_SEL <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    chk("idx x16", 32'h1221EE, 32'(INDEXED_ADDR));
    // Direct page areas: four 64-byte bases, then base zero alone.
    apb(1'b1, 8'h18, 32'h03000100);
    apb(1'b1, 8'h1C, 32'h05000400);
    DP_OFFSET <= 8'hC5;
    repeat (2) @(posedge CLK_SYS);
    chk("dp four", 32'h000505, 32'(DIRECT_ADDR));
    apb(1'b1, 8'h00, 32'h0);
    repeat (2) @(posedge CLK_SYS);
    chk("dp one", 32'h0001C5, 32'(DIRECT_ADDR));
    // Interrupt entry and return; entry is checked to leave the accumulators alone.
    op(crs_pkg::CRS_OP_INT_ENTRY, 32'h024000);
    ctx(16'h4000, 8'h02, 16'h0FFA);
    chk("a kept", 32'h1266AB55, ACC_E);
    op(crs_pkg::CRS_OP_WRITE, 32'h89ABCDEF, crs_pkg::CRS_REG_E);
    chk("e wide", 32'h89ABCDEF, ACC_E);
    op(crs_pkg::CRS_OP_INT_RETURN, 32'h0);
    ctx(16'h1234, 8'h00, 16'h0FFF);
    chk("status", 32'hBEEF, 32'(STATUS_OUT));
    // Nested long and short calls, unwound in order.
    op(crs_pkg::CRS_OP_CALL_LONG, 32'h035000);
    ctx(16'h5000, 8'h03, 16'h0FFC);
    op(crs_pkg::CRS_OP_CALL_SHORT, 32'h006000);
    ctx(16'h6000, 8'h03, 16'h0FFA);
    op(crs_pkg::CRS_OP_RET_SHORT, 32'h0);
    ctx(16'h5000, 8'h03, 16'h0FFC);
    op(crs_pkg::CRS_OP_RET_LONG, 32'h0);
    ctx(16'h1234, 8'h00, 16'h0FFF);
    // Borrow below bank zero, then carry back across it.
    op(crs_pkg::CRS_OP_PC_ADD, 32'hEDCB);
    ctx(16'hFFFF, 8'hFF, 16'h0FFF);
    op(crs_pkg::CRS_OP_PC_ADD, 32'h1);
    ctx(16'h0000, 8'h00, 16'h0FFF);
    // A second reset in mid-run restores the documented values.
    RST <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    RST <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    ctx(16'h1234, 8'h00, 16'h0FFF);
    chk("dt", 32'h0, 32'(DATA_BANK));
    report_and_stop();
  end
endmodule
